/* File: core/tifv_device_end.sv */
// module: timer interrupt flags, request gating and vector dispatch
`timescale 1ns/1ps
`default_nettype none
module tifv_device_end #(
  parameter logic [15:0] BOOT_ADDR = 16'h1000 // start address with boot fuse programmed
) (
  input  wire logic                          MCLK_IN,
  input  wire logic                          SRST_IN,
  tifv_link_if.device                        LINK,
  // wide timer events and compare inputs
  input  wire logic                          CAPTURE_DONE_IN,
  input  wire logic                          WIDE_TICK_IN,
  input  wire logic [tifv_pkg::WIDE_W-1:0]   WIDE_COUNT_IN,
  input  wire logic [tifv_pkg::WIDE_W-1:0]   COMPARE_A_VALUE_IN,
  input  wire logic [tifv_pkg::WIDE_W-1:0]   COMPARE_B_VALUE_IN,
  input  wire logic                          WIDE_WRAP_IN,
  input  wire logic                          WIDE_UPDOWN_IN,
  input  wire logic                          WIDE_DOWN_IN,
  // narrow timer events
  input  wire logic                          NARROW_WRAP_IN,
  input  wire logic                          NARROW2_WRAP_IN,
  input  wire logic                          NARROW2_UPDOWN_IN,
  input  wire logic                          NARROW2_DOWN_IN,
  input  wire logic [tifv_pkg::NARROW_W-1:0] NARROW2_COUNT_IN,
  // other sources and the boot strap pin
  input  wire logic [tifv_pkg::EXT_N-1:0]    EXT_EVENT_IN,
  input  wire logic                          BOOT_FUSE_PROGRAMMED_IN
);
  import tifv_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  // the packing of addresses, enables and vectors needs these sizes
  if (ADDR_W != 16) begin : g_bad_addr
    $error("tifv_device_end: address width must be 16");
  end
  if (FLAG_W != 8) begin : g_bad_flag_w
    $error("tifv_device_end: flag width must be 8");
  end
  if (EN_EXT_LSB + EXT_N > EN_W) begin : g_bad_en_w
    $error("tifv_device_end: enable word too narrow");
  end
  if (VEC_EXT_FIRST + EXT_N > VEC_N) begin : g_bad_vec_n
    $error("tifv_device_end: vector table too short");
  end

  // ****************************************
  // signals
  // ****************************************
  // registered state and its next value
  tifv_dev_state_type  s;
  tifv_dev_state_type  next_s;

  // per bit: set, clear, contents, gated request
  logic [FLAG_W-1:0]   flag_set;
  logic [FLAG_W-1:0]   flag_clear;
  logic [FLAG_W-1:0]   flag_q;
  logic [FLAG_W-1:0]   flag_pend;
  logic [EXT_N-1:0]    ext_pend;

  // one-cycle timer events
  logic                wide_turn;
  logic                narrow2_turn;
  logic                cmp_a_hit;
  logic                cmp_b_hit;

  // one bit per vector number
  logic [VEC_N-1:0]    pending;

  // ****************************************
  // event detection
  // ****************************************

  // direction turns from down to up while the count stands at zero
  // history flops reset low, so no false turn follows reset
  assign wide_turn    = s.wide_down_prev & ~WIDE_DOWN_IN
                        & (WIDE_COUNT_IN == {WIDE_W{1'b0}});
  assign narrow2_turn = s.narrow2_down_prev & ~NARROW2_DOWN_IN
                        & (NARROW2_COUNT_IN == {NARROW_W{1'b0}});

  // compare matches judged only on a fresh count value, so a count
  // parked on the compare value cannot set a cleared flag again
  assign cmp_a_hit = WIDE_TICK_IN & (WIDE_COUNT_IN == COMPARE_A_VALUE_IN); // RQ3
  assign cmp_b_hit = WIDE_TICK_IN & (WIDE_COUNT_IN == COMPARE_B_VALUE_IN); // RQ6

  // hardware set sources per flag bit
  // each source is a one-cycle pulse or a detected edge
  always_comb begin
    flag_set                   = '0;
    flag_set[FLAG_CAPTURE]     = CAPTURE_DONE_IN; // RQ1
    flag_set[FLAG_CMP_A]       = cmp_a_hit;       // RQ3
    flag_set[FLAG_CMP_B]       = cmp_b_hit;       // RQ6

    // overflow in normal modes, bottom turn in up/down mode
    flag_set[FLAG_WIDE_OVF]    = WIDE_UPDOWN_IN ? wide_turn : WIDE_WRAP_IN; // RQ9 RQ10
    flag_set[FLAG_NARROW_OVF]  = NARROW_WRAP_IN;  // RQ13
    flag_set[FLAG_NARROW2_OVF] = NARROW2_UPDOWN_IN ? narrow2_turn : NARROW2_WRAP_IN; // RQ17
    // reserved and spare bits never set and read zero
    flag_set[FLAG_RESERVED]    = 1'b0;            // RQ16
    flag_set[FLAG_SPARE]       = 1'b0;
  end

  // ****************************************
  // flag cells
  // ****************************************

  // one cell per bit; clear by one-write or by taking its own vector
  // bits 1 and 7 have no vector; only a one-write reaches them
  for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
    assign flag_clear[i] = (LINK.flag_clr & LINK.flag_clr_mask[i]) // RQ2 RQ4 RQ7 RQ11 RQ14 RQ20
                           | (LINK.take & (FLAG_VEC[i] != VEC_NONE)
                              & (LINK.take_vec == FLAG_VEC[i])); // RQ21

    // request needs global bit, enable and flag together
    assign flag_pend[i]  = LINK.global_irq & LINK.irq_enable[i] & flag_q[i]; // RQ5 RQ8 RQ12 RQ15

    // the cell decides set against clear
    tifv_flag_cell u_cell (
      .MCLK_IN  (MCLK_IN),
      .SRST_IN  (SRST_IN),
      .SET_IN   (flag_set[i]),
      .CLEAR_IN (flag_clear[i]),
      .FLAG_OUT (flag_q[i])
    );
  end

  // other sources keep their own flags; only gated here
  // a level held high keeps requesting until its source drops it
  for (genvar k = 0; k < EXT_N; k++) begin : g_ext
    assign ext_pend[k] = LINK.global_irq & LINK.irq_enable[EN_EXT_LSB + k]
                         & EXT_EVENT_IN[k];
  end

  // ****************************************
  // vector dispatch
  // ****************************************

  // map every pending source onto its vector number
  // bits 1 and 7 fall on vector 0, which the scan never serves
  always_comb begin
    pending = '0;
    for (int i = 0; i < FLAG_W; i++) begin
      pending[FLAG_VEC[i]] = pending[FLAG_VEC[i]] | flag_pend[i]; // RQ18
    end
    for (int k = 0; k < EXT_N; k++) begin
      pending[VEC_EXT_FIRST + k] = ext_pend[k]; // RQ18
    end
  end

  // state update: strap sync, direction history, lowest vector wins
  always_comb begin
    next_s                   = s;

    // fuse pin passes two flops before the start address reads it
    next_s.fuse_s1           = BOOT_FUSE_PROGRAMMED_IN;
    next_s.fuse_s2           = s.fuse_s1;
    next_s.reset_addr        = s.fuse_s2 ? BOOT_ADDR : RESET_ADDR_APP; // RQ19

    // last cycle's direction, for the reversal detectors
    next_s.wide_down_prev    = WIDE_DOWN_IN;
    next_s.narrow2_down_prev = NARROW2_DOWN_IN;

    // nothing pending unless the scan below finds a source
    next_s.irq_req           = 1'b0;
    next_s.irq_vec           = VEC_NONE;
    // scan downward so the lowest pending number is left standing
    // vector 0 is skipped: it is the reset entry, not a source
    for (int v = VEC_N - 1; v > 0; v--) begin
      if (pending[v]) begin
        next_s.irq_req = 1'b1; // RQ21
        next_s.irq_vec = VEC_W'(v);
      end
    end

    // program address is twice (vector number - 1); idle reads zero
    next_s.irq_addr = '0;
    if (next_s.irq_req) begin
      next_s.irq_addr = {{(ADDR_W - VEC_W - 1){1'b0}}, next_s.irq_vec - VEC_W'(1), 1'b0}; // RQ18
    end

    // reset overrides everything, the fuse chain included
    if (SRST_IN) begin
      next_s = DEV_STATE_RESET;
    end
  end

  // state register
  // reset is folded into next_s, so no branch here
  always_ff @(posedge MCLK_IN) begin
    s <= next_s;
  end

  // ****************************************
  // outputs
  // ****************************************
  // every link output comes straight from a flop
  assign LINK.flag_rdata = flag_q; // reserved bits read zero

  // request, vector and address move together
  assign LINK.irq_req    = s.irq_req;
  assign LINK.irq_vec    = s.irq_vec;
  assign LINK.irq_addr   = s.irq_addr;
  assign LINK.reset_addr = s.reset_addr;

endmodule // tifv_device_end
`default_nettype wire

/* File: core/tifv_pkg.sv */
// package: constants, types and state layouts of the timer interrupt flag block
// Function
// (RQ1) capture done sets capture flag bit 5
// (RQ2) capture flag cleared by vector or one-write
// (RQ3) count equals compare A sets bit 4
// (RQ4) compare A flag cleared by vector or one-write
// (RQ5) compare A request needs global, enable, flag
// (RQ6) count equals compare B sets bit 3
// (RQ7) compare B flag cleared by vector or one-write
// (RQ8) compare B request needs global, enable, flag
// (RQ9) wide timer overflow sets bit 2
// (RQ10) up/down mode: reversal at zero sets bit 2
// (RQ11) wide overflow flag cleared by vector or one-write
// (RQ12) wide overflow request needs global, enable, flag
// (RQ13) narrow timer overflow sets bit 0
// (RQ14) narrow overflow flag cleared by vector or one-write
// (RQ15) narrow overflow request needs global, enable, flag
// (RQ16) bit 1 reserved, value not checked
// (RQ17) up/down mode: second narrow reversal sets flag
// (RQ18) fixed vector numbers and addresses for sources
// (RQ19) programmed boot fuse selects boot reset address
// (RQ20) zero write keeps flag; set beats clear
// (RQ21) lowest vector served first, only it cleared
package tifv_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int WIDE_W   = 16;
  localparam int NARROW_W = 8;
  localparam int ADDR_W   = 16;
  localparam int VEC_W    = 5;
  localparam int FLAG_W   = 8;
  localparam int EXT_N    = 6;
  localparam int EN_W     = 14;
  localparam int VEC_N    = 19;

  // ****************************************
  // flag register bit positions and reset
  // ****************************************
  localparam int FLAG_NARROW_OVF  = 0;
  localparam int FLAG_RESERVED    = 1;
  localparam int FLAG_WIDE_OVF    = 2;
  localparam int FLAG_CMP_B       = 3;
  localparam int FLAG_CMP_A       = 4;
  localparam int FLAG_CAPTURE     = 5;
  localparam int FLAG_NARROW2_OVF = 6;
  localparam int FLAG_SPARE       = 7;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;

  // ****************************************
  // vector numbers; program address is twice (number - 1)
  // ****************************************
  localparam logic [VEC_W-1:0] VEC_NONE        = 5'h00;
  localparam logic [VEC_W-1:0] VEC_NARROW2_OVF = 5'h05;
  localparam logic [VEC_W-1:0] VEC_CAPTURE     = 5'h06;
  localparam logic [VEC_W-1:0] VEC_CMP_A       = 5'h07;
  localparam logic [VEC_W-1:0] VEC_CMP_B       = 5'h08;
  localparam logic [VEC_W-1:0] VEC_WIDE_OVF    = 5'h09;
  localparam logic [VEC_W-1:0] VEC_NARROW_OVF  = 5'h0a;
  localparam logic [VEC_W-1:0] VEC_EXT_FIRST   = 5'h0d; // tx empty, tx done, conv, nvm, comp, twi
  // vector of each flag bit, index = bit position
  localparam logic [FLAG_W-1:0][VEC_W-1:0] FLAG_VEC = {
    VEC_NONE, VEC_NARROW2_OVF, VEC_CAPTURE, VEC_CMP_A,
    VEC_CMP_B, VEC_WIDE_OVF, VEC_NONE, VEC_NARROW_OVF};
  localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 16'h0000;

  // ****************************************
  // controller register map (byte offsets) and fields
  // ****************************************
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_ENABLE    = 8'h04;
  localparam logic [7:0] REG_FLAGS     = 8'h08;
  localparam logic [7:0] REG_VECTOR    = 8'h0c;
  localparam logic [7:0] REG_RESET_ADR = 8'h10;
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int EN_EXT_LSB      = 8;
  localparam int VECREG_REQ_BIT  = 31;
  localparam int VECREG_NUM_LSB  = 16;

  // ****************************************
  // state types
  // ****************************************
  typedef struct packed {
    logic flag;
  } tifv_cell_state_type;

  typedef struct packed {
    logic              fuse_s1;
    logic              fuse_s2;
    logic              wide_down_prev;
    logic              narrow2_down_prev;
    logic              irq_req;
    logic [VEC_W-1:0]  irq_vec;
    logic [ADDR_W-1:0] irq_addr;
    logic [ADDR_W-1:0] reset_addr;
  } tifv_dev_state_type;

  localparam tifv_dev_state_type DEV_STATE_RESET = '0;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } tifv_bus_type;

  typedef struct packed {
    tifv_bus_type      bus;
    logic              wr;
    logic [7:0]        addr;
    logic [31:0]       hrdata;
    logic              hreadyout;
    logic              hresp;
    logic              global_en;
    logic [EN_W-1:0]   enable;
    logic              flag_clr;
    logic [FLAG_W-1:0] flag_clr_mask;
    logic              take;
    logic [VEC_W-1:0]  take_vec;
  } tifv_host_state_type;

  localparam tifv_host_state_type HOST_STATE_RESET = '{
    bus: BUS_IDLE, wr: 1'b0, addr: 8'h00, hrdata: 32'h0000_0000,
    hreadyout: 1'b1, hresp: 1'b0, global_en: 1'b0, enable: 14'h0000,
    flag_clr: 1'b0, flag_clr_mask: 8'h00, take: 1'b0, take_vec: 5'h00};

endpackage

/* File: core/tifv_link_if.sv */
// interface: link between the flag block and the processor core side
`timescale 1ns/1ps
`default_nettype none
interface tifv_link_if;
  import tifv_pkg::*;

  logic                  global_irq;    // processor status word global bit
  logic [EN_W-1:0]       irq_enable;    // per-source enables
  logic                  flag_clr;      // pulse: write-one clear
  logic [FLAG_W-1:0]     flag_clr_mask; // ones clear, zeros keep
  logic                  take;          // pulse: vector taken
  logic [VEC_W-1:0]      take_vec;      // number of the vector taken
  logic [FLAG_W-1:0]     flag_rdata;    // flag register contents
  logic                  irq_req;       // a request is pending
  logic [VEC_W-1:0]      irq_vec;       // winning vector number
  logic [ADDR_W-1:0]     irq_addr;      // winning program address
  logic [ADDR_W-1:0]     reset_addr;    // start address after reset

  modport device (
    input  global_irq, irq_enable, flag_clr, flag_clr_mask, take, take_vec,
    output flag_rdata, irq_req, irq_vec, irq_addr, reset_addr
  );

  modport host (
    output global_irq, irq_enable, flag_clr, flag_clr_mask, take, take_vec,
    input  flag_rdata, irq_req, irq_vec, irq_addr, reset_addr
  );
endinterface
`default_nettype wire

/* File: core/tifv_flag_cell.sv */
// module: one sticky interrupt flag, hardware set wins over clear
`timescale 1ns/1ps
`default_nettype none
module tifv_flag_cell (
  input  wire logic MCLK_IN,
  input  wire logic SRST_IN,
  input  wire logic SET_IN,
  input  wire logic CLEAR_IN,
  output logic      FLAG_OUT
);
  import tifv_pkg::*;

  tifv_cell_state_type s;
  tifv_cell_state_type next_s;

  // set beats a clear in the same cycle, no event lost
  always_comb begin
    next_s = s;
    if (SET_IN) begin
      next_s.flag = 1'b1; // RQ20
    end else if (CLEAR_IN) begin
      next_s.flag = 1'b0;
    end
    if (SRST_IN) begin
      next_s.flag = 1'b0;
    end
  end

  // state register
  always_ff @(posedge MCLK_IN) begin
    s <= next_s;
  end

  assign FLAG_OUT = s.flag;
endmodule // tifv_flag_cell
`default_nettype wire

/* File: core/tifv_host_end.sv */
// module: processor side, AHB-Lite register slave driving the link
`timescale 1ns/1ps
`default_nettype none
module tifv_host_end (
  input  wire logic        MCLK_IN,
  input  wire logic        SRST_IN,
  tifv_link_if.host        LINK,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT
);
  import tifv_pkg::*;

  tifv_host_state_type s;
  tifv_host_state_type next_s;
  logic                hit;

  // only word transfers are meaningful; narrower sizes act as words
  assign hit = HSEL_IN & HTRANS_IN[1] & HREADY_IN & (HSIZE_IN <= 3'h2);

  // write data phase first, then a new address phase to control or enable reads the result
  always_comb begin
    next_s          = s;
    next_s.flag_clr = 1'b0;
    next_s.take     = 1'b0;
    if (s.bus == BUS_DATA && s.wr) begin
      case (s.addr)
        REG_CTRL: begin
          next_s.global_en = HWDATA_IN[CTRL_GLOBAL_BIT];
        end
        REG_ENABLE: begin
          next_s.enable = HWDATA_IN[EN_W-1:0];
        end
        REG_FLAGS: begin
          next_s.flag_clr      = 1'b1; // RQ2 RQ4 RQ7 RQ11 RQ14
          next_s.flag_clr_mask = HWDATA_IN[FLAG_W-1:0];
        end
        REG_VECTOR: begin
          // entering a vector clears the global bit, as the core does
          if (LINK.irq_req) begin
            next_s.take      = 1'b1;
            next_s.take_vec  = LINK.irq_vec;
            next_s.global_en = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    next_s.bus = BUS_IDLE;
    if (hit) begin
      next_s.bus  = BUS_DATA;
      next_s.wr   = HWRITE_IN;
      next_s.addr = HADDR_IN[7:0];
      if (!HWRITE_IN) begin
        case (HADDR_IN[7:0])
          REG_CTRL:      next_s.hrdata = {31'h0000_0000, next_s.global_en};
          REG_ENABLE:    next_s.hrdata = {18'h0_0000, next_s.enable};
          REG_FLAGS:     next_s.hrdata = {24'h00_0000, LINK.flag_rdata};
          REG_VECTOR:    next_s.hrdata = {LINK.irq_req, 10'h000, LINK.irq_vec,
                                          LINK.irq_addr};
          REG_RESET_ADR: next_s.hrdata = {16'h0000, LINK.reset_addr};
          default:       next_s.hrdata = 32'h0000_0000;
        endcase
      end
    end
    next_s.hreadyout = 1'b1;
    next_s.hresp     = 1'b0;
    if (SRST_IN) begin
      next_s = HOST_STATE_RESET;
    end
  end

  // state register
  always_ff @(posedge MCLK_IN) begin
    s <= next_s;
  end

  assign HRDATA_OUT         = s.hrdata;
  assign HREADYOUT_OUT      = s.hreadyout;
  assign HRESP_OUT          = s.hresp;
  assign LINK.global_irq    = s.global_en;
  assign LINK.irq_enable    = s.enable;
  assign LINK.flag_clr      = s.flag_clr;
  assign LINK.flag_clr_mask = s.flag_clr_mask;
  assign LINK.take          = s.take;
  assign LINK.take_vec      = s.take_vec;

endmodule // tifv_host_end
`default_nettype wire

/* File: dv/tifv_link_props.sv */
// checker: link-level properties of the timer interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module tifv_link_props (
  input wire logic                        MCLK_IN,
  input wire logic                        SRST_IN,
  input wire logic                        global_irq,
  input wire logic [tifv_pkg::EN_W-1:0]   irq_enable,
  input wire logic                        flag_clr,
  input wire logic [tifv_pkg::FLAG_W-1:0] flag_clr_mask,
  input wire logic                        take,
  input wire logic [tifv_pkg::VEC_W-1:0]  take_vec,
  input wire logic [tifv_pkg::FLAG_W-1:0] flag_rdata,
  input wire logic                        irq_req,
  input wire logic [tifv_pkg::VEC_W-1:0]  irq_vec,
  input wire logic [tifv_pkg::ADDR_W-1:0] irq_addr,
  input wire logic [tifv_pkg::ADDR_W-1:0] reset_addr
);
  import tifv_pkg::*;

  logic                exp_any;
  logic [VEC_W-1:0]    exp_vec;
  logic [FLAG_W-1:0]   allow_fall;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);

  // ****************************************
  // helper: expected winner and permitted flag drops
  // ****************************************
  // highest bit pending is the lowest vector
  always_ff @(posedge MCLK_IN) begin
    exp_any <= 1'b0;
    exp_vec <= VEC_NONE;
    for (int k = 0; k < FLAG_W; k++) begin
      if (global_irq && irq_enable[k] && flag_rdata[k] && FLAG_VEC[k] != VEC_NONE) begin
        exp_any <= 1'b1;
        exp_vec <= FLAG_VEC[k];
      end
      allow_fall[k] <= (flag_clr && flag_clr_mask[k]) || (take && take_vec == FLAG_VEC[k]);
    end
  end

  // ****************************************
  // properties
  // ****************************************
  property p_arb_fire;
    exp_any |-> irq_req && irq_vec == exp_vec;
  endproperty
  a_arb_fire: assert property (p_arb_fire) else $error("pending flag not dispatched");
  property p_arb_only;
    irq_req && irq_vec < VEC_EXT_FIRST |-> exp_any && irq_vec == exp_vec;
  endproperty
  a_arb_only: assert property (p_arb_only) else $error("request without gated flag");
  property p_cmpb_gate;
    irq_req && irq_vec == VEC_CMP_B |->
      $past(global_irq && irq_enable[FLAG_CMP_B] && flag_rdata[FLAG_CMP_B]);
  endproperty
  a_cmpb_gate: assert property (p_cmpb_gate) else $error("compare b gating");
  property p_wovf_gate;
    irq_req && irq_vec == VEC_WIDE_OVF |-> $past(flag_rdata[FLAG_WIDE_OVF])
      && $past(global_irq) && $past(irq_enable[FLAG_WIDE_OVF]);
  endproperty
  a_wovf_gate: assert property (p_wovf_gate) else $error("wide overflow gating");
  property p_novf_gate;
    !$past(global_irq) |-> !(irq_req && irq_vec == VEC_NARROW_OVF);
  endproperty
  a_novf_gate: assert property (p_novf_gate) else $error("narrow overflow gating");
  property p_no_fall;
    (~flag_rdata & $past(flag_rdata) & ~allow_fall) == 8'h00;
  endproperty
  a_no_fall: assert property (p_no_fall) else $error("flag dropped without clear");
  property p_take_vec;
    take |-> $past(irq_req) && take_vec == $past(irq_vec);
  endproperty
  a_take_vec: assert property (p_take_vec) else $error("taken vector not the winner");
  property p_addr_flag;
    irq_req && irq_vec < VEC_EXT_FIRST |-> irq_addr == {10'h000, irq_vec - 5'h01, 1'b0};
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("timer vector address");
  property p_addr_ext;
    irq_req && irq_vec >= VEC_EXT_FIRST |->
      irq_addr == 16'h0018 + {10'h000, irq_vec - 5'h0d, 1'b0};
  endproperty
  a_addr_ext: assert property (p_addr_ext) else $error("peripheral vector address");
endmodule // tifv_link_props
`default_nettype wire

/* File: dv/timer_irq_flags_and_vectors_bench.sv */
// testbench: both ends joined, driven over the register bus
`timescale 1ns/1ps
`default_nettype none
module timer_irq_flags_and_vectors_bench;
  import tifv_pkg::*;
  localparam logic [15:0] BOOT_A = 16'h2468; // arbitrary boot address
  localparam logic [7:0] EXPB [9] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h04, 8'h40, 8'h00, 8'h00};
  localparam logic [4:0] VEX [7] = '{5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h09, 5'h05};
  logic        mclk, rst, capt, tick, wwrap, wud, wdn, nwrap, n2wrap, n2ud, n2dn, fuse;
  logic [15:0] cnt, cmpa, cmpb;
  logic [7:0]  n2cnt;
  logic [5:0]  ext;
  logic        hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          n_mismatch = 0;
  int          n_checks = 0;

  tifv_link_if tifv_link_if_inst ();
  tifv_device_end #(.BOOT_ADDR(BOOT_A)) tifv_device_end_inst (
    .MCLK_IN(mclk), .SRST_IN(rst), .LINK(tifv_link_if_inst), .CAPTURE_DONE_IN(capt),
    .WIDE_TICK_IN(tick), .WIDE_COUNT_IN(cnt), .COMPARE_A_VALUE_IN(cmpa),
    .COMPARE_B_VALUE_IN(cmpb), .WIDE_WRAP_IN(wwrap), .WIDE_UPDOWN_IN(wud), .WIDE_DOWN_IN(wdn),
    .NARROW_WRAP_IN(nwrap), .NARROW2_WRAP_IN(n2wrap), .NARROW2_UPDOWN_IN(n2ud),
    .NARROW2_DOWN_IN(n2dn), .NARROW2_COUNT_IN(n2cnt), .EXT_EVENT_IN(ext),
    .BOOT_FUSE_PROGRAMMED_IN(fuse));
  tifv_host_end tifv_host_end_inst (
    .MCLK_IN(mclk), .SRST_IN(rst), .LINK(tifv_link_if_inst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp));
  tifv_link_props tifv_link_props_inst (
    .MCLK_IN(mclk), .SRST_IN(rst), .global_irq(tifv_link_if_inst.global_irq),
    .irq_enable(tifv_link_if_inst.irq_enable), .flag_clr(tifv_link_if_inst.flag_clr),
    .flag_clr_mask(tifv_link_if_inst.flag_clr_mask), .take(tifv_link_if_inst.take),
    .take_vec(tifv_link_if_inst.take_vec), .flag_rdata(tifv_link_if_inst.flag_rdata),
    .irq_req(tifv_link_if_inst.irq_req), .irq_vec(tifv_link_if_inst.irq_vec),
    .irq_addr(tifv_link_if_inst.irq_addr), .reset_addr(tifv_link_if_inst.reset_addr));

  // ****************************************
  // tasks
  // ****************************************
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one single-word transfer, zero-wait or stretched
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  // flags read with reserved bits masked off
  task automatic rdf();
    repeat (2) @(posedge mclk);
    bus(1'b0, REG_FLAGS, 32'h0);
    rd = rd & 32'h0000_007d;
  endtask
  task automatic rv();
    repeat (2) @(posedge mclk);
    bus(1'b0, REG_VECTOR, 32'h0);
  endtask
  function automatic logic [31:0] vx(input logic [4:0] v);
    return {1'b1, 10'h000, v, 10'h000, v - 5'h01, 1'b0};
  endfunction
  // one timer event; 7 and 8 must not set anything
  task automatic ev(input int i);
    case (i)
      0: capt <= 1'b1;
      1: {tick, cnt} <= {1'b1, cmpa};
      2: {tick, cnt} <= {1'b1, cmpb};
      3: wwrap <= 1'b1;
      4: nwrap <= 1'b1;
      5: {wud, wdn, cnt} <= {2'b11, 16'h0000};
      6: {n2ud, n2dn, n2cnt} <= {2'b11, 8'h00};
      7: {tick, cnt} <= {1'b1, cmpa + 16'h0001};
      default: {wud, wwrap} <= 2'b11;
    endcase
    @(posedge mclk);
    {capt, tick, wwrap, nwrap, wdn, n2dn} <= 6'h00;
    @(posedge mclk);
    {wud, n2ud} <= 2'b00;
    @(posedge mclk);
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {rst, fuse, hsize, cmpa, cmpb} = {2'b11, 3'b010, 16'h1234, 16'h8000};
    {capt, tick, wwrap, wud, wdn, nwrap, n2wrap, n2ud, n2dn, hsel, hwrite} = 11'h000;
    {cnt, n2cnt, ext, htrans, haddr, hwdata} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    bus(1'b0, REG_RESET_ADR, 32'h0);
    chk(rd, {16'h0, BOOT_A});
    for (int i = 0; i < 9; i++) begin
      ev(i);
      rdf();
      chk(rd, {24'h0, EXPB[i]});
      bus(1'b1, REG_FLAGS, 32'h0);
      rdf();
      chk(rd, {24'h0, EXPB[i]});
      bus(1'b1, REG_FLAGS, {24'h0, EXPB[i]});
      rdf();
      chk(rd, 32'h0);
    end
    bus(1'b1, REG_ENABLE, 32'h0000_3fff);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, REG_CTRL, 32'h1);
      ev(i);
      rv();
      chk(rd, vx(VEX[i]));
      bus(1'b1, REG_VECTOR, 32'h0);
      rdf();
      chk(rd, 32'h0);
    end
    // three pending together: lowest vector first, only it cleared
    bus(1'b1, REG_CTRL, 32'h1);
    ev(0);
    ev(1);
    ev(4);
    rv();
    chk(rd, vx(VEC_CAPTURE));
    bus(1'b1, REG_VECTOR, 32'h0);
    rdf();
    chk(rd, 32'h11);
    bus(1'b1, REG_ENABLE, 32'h0000_3fef);
    bus(1'b1, REG_CTRL, 32'h1);
    rv();
    chk(rd, vx(VEC_NARROW_OVF));
    bus(1'b1, REG_ENABLE, 32'h0000_3fee);
    rv();
    chk(rd & 32'h8000_0000, 32'h0);
    bus(1'b1, REG_ENABLE, 32'h0000_3fff);
    bus(1'b1, REG_CTRL, 32'h0);
    rv();
    chk(rd & 32'h8000_0000, 32'h0);
    bus(1'b1, REG_FLAGS, 32'h11);
    bus(1'b1, REG_CTRL, 32'h1);
    for (int k = 0; k < 6; k++) begin
      ext <= 6'(1 << k);
      rv();
      chk(rd, {1'b1, 10'h000, 5'(13 + k), 16'(24 + 2 * k)});
    end
    ext <= 6'h00;
    // hardware set meets a write-one clear at the same edge
    ev(0);
    bus(1'b1, REG_FLAGS, 32'h20);
    capt <= 1'b1;
    @(posedge mclk);
    capt <= 1'b0;
    rdf();
    chk(rd, 32'h20);
    fuse <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rdf();
    chk(rd, 32'h0);
    bus(1'b0, REG_RESET_ADR, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule // timer_irq_flags_and_vectors_bench
`default_nettype wire
